// ### bench/clock_chip_serial_control_port_tb_top.sv
// Testbench: host model drives the port, a scoreboard checks each byte read back.
// Assumes the checker is bound to the port from its own file.
`default_nettype none

module clock_chip_serial_control_port_tb_top
   import serial_port_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic pd_n = 1'b1;
   logic use_sdo = 1'b0;
   logic cs_n, sclk, h_d, h_oe, rx_stb, sdio_o, sdio_oe, sdo_o, sdo_oe, sleep, upd;
   logic [7:0] rx;
   logic [7:0] upd_cnt = 8'h00;
   logic [7:0] q[$];
   logic [7:0] exp_q[$];
   logic [7:0] d0, d1, d2;
   logic [31:0] seed = 32'h868b;
   int bad_count = 0;
   int total_checks = 0;
   // A released sdio line shows the inverse of the host's bit; a released output line the inverse of the port's bit
   wire logic sdio_w = sdio_oe ? sdio_o : (h_oe ? h_d : ~h_d);
   wire logic sdo_w = sdo_oe ? sdo_o : ~sdo_o;

   initial begin
      forever #50 clk_in = ~clk_in;
   end

   serial_control_port dut_u (.clk_in(clk_in), .nrst_in(nrst_in), .cs_n_in(cs_n), .sclk_in(sclk),
      .sdio_in(sdio_w), .sdio_out(sdio_o), .sdio_oe_out(sdio_oe), .readback_output_line_out(sdo_o),
      .readback_output_line_oe_out(sdo_oe), .power_down_pin_n_in(pd_n), .sleep_out(sleep),
      .update_pulse_out(upd));
   serial_host_model host_u (.clk_in(clk_in), .sd_in(use_sdo ? sdo_w : sdio_w), .cs_n_out(cs_n),
      .sclk_out(sclk), .sd_out(h_d), .sd_oe_out(h_oe), .rx_byte_out(rx), .rx_stb_out(rx_stb));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish

   task automatic ins(input logic is_rd, input logic [1:0] len, input logic [12:0] a);
      logic [15:0] w;
      w = {is_rd, len, a};
      host_u.sel();
      if (host_u.lsb_first) begin
         host_u.shift_byte(w[7:0], 1'b1);
         host_u.shift_byte(w[15:8], 1'b1);
      end else begin
         host_u.shift_byte(w[15:8], 1'b1);
         host_u.shift_byte(w[7:0], 1'b1);
      end
   endtask : ins

   task automatic wr(input logic [1:0] len, input logic [12:0] a, input logic [7:0] d[$]);
      ins(1'b0, len, a);
      foreach (d[i]) host_u.shift_byte(d[i], 1'b1);
      host_u.desel();
   endtask : wr

   // Expectations are queued before each byte is clocked out
   task automatic rd(input logic [1:0] len, input logic [12:0] a, input logic [7:0] e[$]);
      ins(1'b1, len, a);
      foreach (e[i]) begin
         exp_q.push_back(e[i]);
         host_u.shift_byte(8'h00, 1'b0);
      end
      host_u.desel();
   endtask : rd

   // Scoreboard: every byte the host takes is matched with the oldest note
   always @(posedge clk_in) begin
      if (upd === 1'b1) upd_cnt <= upd_cnt + 8'h01;
      if (rx_stb === 1'b1) begin
         if (exp_q.size() == 0) begin
            bad_count++;
            $display("ERROR readback expected none seen %h", rx);
         end else begin
            check("readback", rx, exp_q.pop_front());
         end
      end
   end

   initial begin
      repeat (4) @(negedge clk_in);
      nrst_in = 1'b1;
      repeat (4) @(negedge clk_in);
      rd(LEN_ONE, 13'h000, '{8'h18});
      rd(LEN_TWO, 13'h004, '{8'h00, 8'h00});
      $display("test reset values done");
      // Every short length with the chip asleep; the port must keep serving
      pd_n = 1'b0;
      for (int i = 0; i < 3; i++) begin
         q.delete();
         for (int j = 0; j <= i; j++) begin
            seed = lfsr(seed);
            q.push_back(seed[7:0]);
         end
         wr(2'(i), 13'h052, q);
         rd(2'(i), 13'h052, q);
      end
      // An address with the top bit set is refused both ways
      wr(LEN_ONE, 13'h1052, '{~q[0]});
      rd(LEN_ONE, 13'h052, '{q[0]});
      rd(LEN_ONE, 13'h1052, '{8'h00});
      check("sleep", {7'h00, sleep}, 8'h01);
      pd_n = 1'b1;
      $display("test lengths done");
      seed = lfsr(seed);
      d0 = seed[7:0];
      d1 = seed[15:8];
      d2 = seed[23:16];
      ins(1'b0, LEN_THREE, 13'h012);
      host_u.shift_byte(d0, 1'b1);
      host_u.desel();
      host_u.sel();
      host_u.shift_byte(d1, 1'b1);
      host_u.shift_byte(d2, 1'b1);
      host_u.desel();
      rd(LEN_ONE, 13'h010, '{d2});
      rd(LEN_THREE, 13'h012, '{d0, d1, d2});
      // Read stalled between instruction and data; the first bit waits in the output flop
      ins(1'b1, LEN_TWO, 13'h012);
      host_u.desel();
      host_u.sel();
      exp_q.push_back(d0);
      host_u.shift_byte(8'h00, 1'b0);
      exp_q.push_back(d1);
      host_u.shift_byte(8'h00, 1'b0);
      host_u.desel();
      $display("test stall done");
      wr(LEN_ONE, 13'h020, '{d1});
      host_u.sel();
      host_u.stub(3);
      host_u.desel();
      ins(1'b0, LEN_ONE, 13'h021);
      host_u.stub(5);
      host_u.desel();
      rd(LEN_TWO, 13'h021, '{8'h00, d1});
      $display("test abort done");
      wr(LEN_ONE, 13'h004, '{8'h01});
      rd(LEN_ONE, 13'h012, '{8'h00});
      wr(LEN_ONE, 13'h232, '{8'h01});
      check("updates", upd_cnt, 8'h01);
      rd(LEN_ONE, 13'h012, '{d0});
      $display("test update done");
      wr(LEN_ONE, 13'h000, '{8'h99});
      use_sdo = 1'b1;
      rd(LEN_ONE, 13'h011, '{d1});
      wr(LEN_ONE, 13'h000, '{8'h5a});
      use_sdo = 1'b0;
      host_u.lsb_first = 1'b1;
      rd(LEN_ONE, 13'h000, '{8'h5a});
      wr(LEN_STREAM, 13'h230, '{d2, d0, 8'h01, 8'h00});
      check("updates", upd_cnt, 8'h02);
      rd(LEN_STREAM, 13'h230, '{d2, d0, 8'h00});
      rd(LEN_TWO, 13'h000, '{8'h5a, 8'h00});
      $display("test modes and stream done");
      tally_and_finish();
   end

   // Some 32 frames of a few hundred cycles each; this allows over three times that
   initial begin
      #2_500_000;
      bad_count++;
      tally_and_finish();
   end
endmodule : clock_chip_serial_control_port_tb_top

`default_nettype wire

// ### bench/serial_host_model.sv
// Host side of the serial link: select, serial clock and data, one byte at a time.
// Assumes callers enter each task just after a falling clk_in edge.
`default_nettype none

module serial_host_model (
   input wire logic clk_in,
   input wire logic sd_in,
   output logic cs_n_out,
   output logic sclk_out,
   output logic sd_out,
   output logic sd_oe_out,
   output logic [7:0] rx_byte_out,
   output logic rx_stb_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic lsb_first = 1'b0;

   // Idle: deselected, clock low as its pull-down leaves it
   initial begin
      cs_n_out = 1'b1;
      sclk_out = 1'b0;
      sd_out = 1'b0;
      sd_oe_out = 1'b0;
      rx_byte_out = 8'h00;
      rx_stb_out = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge clk_in);
   endtask : tick

   task automatic sel();
      cs_n_out = 1'b0;
      tick(4);
   endtask : sel

   // Select rises with the clock already low, on a byte boundary or mid-byte after a stub
   task automatic desel();
      sclk_out = 1'b0;
      sd_oe_out = 1'b0;
      tick(4);
      cs_n_out = 1'b1;
      tick(8);
   endtask : desel

   // Data set in the low half, taken by both sides at the rise
   task automatic shift_byte(input logic [7:0] b, input logic drv);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < 8; i++) begin
         sclk_out = 1'b0;
         sd_oe_out = drv;
         sd_out = lsb_first ? b[i] : b[7-i];
         tick(4);
         sclk_out = 1'b1;
         if (lsb_first) r[i] = sd_in;
         else r[7-i] = sd_in;
         tick(4);
      end
      if (!drv) begin
         rx_byte_out = r;
         rx_stb_out = 1'b1;
         tick(1);
         rx_stb_out = 1'b0;
      end
   endtask : shift_byte

   // A few stray clocks, short of a byte, to force an abort
   task automatic stub(input int n);
      for (int i = 0; i < n; i++) begin
         sclk_out = 1'b0;
         sd_oe_out = 1'b1;
         sd_out = 1'b1;
         tick(4);
         sclk_out = 1'b1;
         tick(4);
      end
   endtask : stub
endmodule : serial_host_model

`default_nettype wire

// ### bench/serial_port_checker_assertions.sv
// Checker for the serial control port pins, bound to the port module.
// Assumes host edges are slow against clk_in and the reset is the raw pin.
`default_nettype none

module serial_port_checker (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic cs_n_in,
   input wire logic sclk_in,
   input wire logic sdio_out,
   input wire logic sdio_oe_out,
   input wire logic readback_output_line_out,
   input wire logic readback_output_line_oe_out,
   input wire logic power_down_pin_n_in,
   input wire logic sleep_out,
   input wire logic update_pulse_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!nrst_in);

   // Pins must be released once the synced select has seen high
   a_quiet_when_idle: assert property (cs_n_in [*4] |-> !sdio_oe_out && !readback_output_line_oe_out)
      else $error("data pin driven while deselected");
   a_one_driver: assert property (!(sdio_oe_out && readback_output_line_oe_out))
      else $error("both data pins driven");
   a_end_on_rise: assert property ($rose(cs_n_in) |-> ##[1:4] !(sdio_oe_out || readback_output_line_oe_out))
      else $error("drive kept after select rose");
   // Drive starts after an instruction or on resuming a stalled read, select low past the synchroniser
   a_drive_after_instr: assert property ($rose(sdio_oe_out || readback_output_line_oe_out)
      |-> !cs_n_in && !$past(cs_n_in, 2))
      else $error("drive began without an instruction");
   // Read bits move only in the low half of the serial clock
   a_bit_on_fall: assert property (sdio_oe_out && $past(sdio_oe_out) && $changed(sdio_out) |-> !sclk_in)
      else $error("read bit changed while clock high");
   a_sdo_on_fall: assert property (readback_output_line_oe_out && $past(readback_output_line_oe_out)
      && $changed(readback_output_line_out) |-> !sclk_in)
      else $error("output line bit changed while clock high");
   a_update_single: assert property (update_pulse_out |=> !update_pulse_out)
      else $error("update pulse longer than one cycle");
   a_update_in_frame: assert property (update_pulse_out |-> !cs_n_in && !$past(cs_n_in, 4))
      else $error("update pulse outside a write");
   a_sleep_on: assert property (!power_down_pin_n_in [*4] |-> sleep_out)
      else $error("sleep missing while pin low");
   a_sleep_off: assert property (power_down_pin_n_in [*4] |-> !sleep_out)
      else $error("sleep while pin high");

   c_update: cover property (update_pulse_out);
   c_sdo_read: cover property (readback_output_line_oe_out);
   c_sleep: cover property (sleep_out && sdio_oe_out);
endmodule : serial_port_checker

bind serial_control_port serial_port_checker chk_u (.clk_in(clk_in), .nrst_in(nrst_in), .cs_n_in(cs_n_in),
   .sclk_in(sclk_in), .sdio_out(sdio_out), .sdio_oe_out(sdio_oe_out),
   .readback_output_line_out(readback_output_line_out),
   .readback_output_line_oe_out(readback_output_line_oe_out),
   .power_down_pin_n_in(power_down_pin_n_in), .sleep_out(sleep_out), .update_pulse_out(update_pulse_out));

`default_nettype wire

// ### design/serial_control_port.sv
// Serial control port: chip select, shift clock and data pins into the register banks.
// Assumes the serial clock is far slower than clk_in; all pins are sampled through two flops.
//
// Contract
// - Sample write bits on serial clock rise, launch read bits on its fall.
// - Readback on bidirectional pin by default, on output-only pin when selected.
// - Both data pins are released while chip select is high.
// - Short transfers may stall with chip select high at byte boundaries, then resume.
// - Chip select rising mid-byte ends transfer, drops partial data, resets port.
// - Streaming moves bytes with auto address up to register_update_trigger; chip select rise ends it sooner.
// - Every transaction starts with a 16-bit instruction on the first 16 rises.
// - Length field picks 1, 2, 3 bytes or streaming; rise after last byte ends.
// - Streaming writes cover reserved and unused addresses without skipping.
// - Writes other than config, readback select and update go to a shadow bank; update bit copies it to active at once.
// - Reads give eight clocks per byte, or stream until chip select rises or the byte at register_update_trigger is sent.
// - Readback source is shadow or active bank per select bit.
// - Addresses serial_port_config through register_update_trigger are decoded.
// - Port keeps working while the chip is powered down.
// - Instruction: read flag, two length bits, 13-bit address with top three zero.
// - Address decrements per byte in MSB-first mode, increments in LSB-first.
// - Streaming stops on its own at address register_update_trigger, unused addresses not skipped.
// - LSB-first selection acts at once, with no update.
`default_nettype none

module serial_control_port
   import serial_port_pkg::*;
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic cs_n_in,
   input wire logic sclk_in,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe_out,
   output logic readback_output_line_out,
   output logic readback_output_line_oe_out,
   input wire logic power_down_pin_n_in,
   output logic sleep_out,
   output logic update_pulse_out
);

   // Bit order reversal, used for the launched byte only
   function automatic logic [7:0] reverse8(input logic [7:0] v);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < 8; i++) begin
         r[i] = v[7-i];
      end
      return r;
   endfunction : reverse8

   // Next address after a byte: down with wrap to the top, or up
   function automatic logic [12:0] next_addr(input logic [12:0] a, input logic lsb_first);
      logic [12:0] n;
      n = a;
      if (lsb_first) begin
         n = a + 13'h0001;
      end else if (a == 13'h0000) begin
         n = ADDR_TOP;
      end else begin
         n = a - 13'h0001;
      end
      return n;
   endfunction : next_addr

   logic rst_meta_reg;
   logic rst_n;
   logic [1:0] cs_sync_reg;
   logic [1:0] sclk_sync_reg;
   logic [1:0] sdio_sync_reg;
   logic [1:0] pd_sync_reg;
   logic sclk_prev_reg;
   logic cs_prev_reg;
   logic cs_n;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_rise;
   logic din;

   port_state_t state_reg;
   logic [3:0] bit_cnt_reg;
   logic [15:0] instr_sr_reg;
   logic [7:0] data_sr_reg;
   instr_t instr_reg;
   logic [12:0] addr_reg;
   logic [1:0] bytes_left_reg;
   logic [7:0] port_config_reg;
   logic [7:0] readback_sel_reg;
   logic update_reg;
   logic [7:0] out_sr_reg;
   logic dout_reg;

   logic lsb_first;
   logic sdo_active;
   logic [15:0] instr_word;
   logic [7:0] data_byte;
   logic byte_done;
   logic last_fixed_byte;
   logic addr_in_range;
   logic in_mem;
   mem_wr_t mem_wr;
   logic [7:0] mem_rd_data;
   logic [7:0] rd_byte;
   logic [7:0] rd_ordered;
   logic reading;

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   // Trade-off: two cycles of latency on every pin, so each serial clock phase needs three clk_in cycles
   // Pin synchronisers; only the second stage is read by logic
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         cs_sync_reg <= 2'h3;
         sclk_sync_reg <= 2'h0;
         sdio_sync_reg <= 2'h0;
         pd_sync_reg <= 2'h3;
         sclk_prev_reg <= 1'b0;
         cs_prev_reg <= 1'b1;
      end else begin
         cs_sync_reg <= {cs_sync_reg[0], cs_n_in};
         sclk_sync_reg <= {sclk_sync_reg[0], sclk_in};
         sdio_sync_reg <= {sdio_sync_reg[0], sdio_in};
         pd_sync_reg <= {pd_sync_reg[0], power_down_pin_n_in};
         sclk_prev_reg <= sclk_sync_reg[1];
         cs_prev_reg <= cs_sync_reg[1];
      end
   end

   // Edges are seen only while selected; a rising shift clock with chip select high is ignored
   assign cs_n = cs_sync_reg[1];
   assign din = sdio_sync_reg[1];
   assign sclk_rise = sclk_sync_reg[1] & ~sclk_prev_reg & ~cs_n;
   assign sclk_fall = ~sclk_sync_reg[1] & sclk_prev_reg & ~cs_n;
   assign cs_rise = cs_n & ~cs_prev_reg;

   // Power-down pin is only reported; the port itself never looks at it
   assign sleep_out = ~pd_sync_reg[1];

   // Port configuration takes effect immediately, from either mirrored copy
   assign lsb_first = port_config_reg[CFG_LSB_FIRST_BIT] | port_config_reg[CFG_LSB_FIRST_MIRROR_BIT];
   assign sdo_active = port_config_reg[CFG_SDO_ACTIVE_BIT] | port_config_reg[CFG_SDO_ACTIVE_MIRROR_BIT];

   // Shift-register values including the bit sampled this edge
   assign instr_word = lsb_first ? {din, instr_sr_reg[15:1]} : {instr_sr_reg[14:0], din};
   assign data_byte = lsb_first ? {din, data_sr_reg[7:1]} : {data_sr_reg[6:0], din};
   assign byte_done = sclk_rise && (state_reg == ST_DATA) && (bit_cnt_reg[2:0] == BYTE_LAST_BIT);
   assign last_fixed_byte = (instr_reg.transfer_length_field != LEN_STREAM) && (bytes_left_reg == 2'h0);

   // Top three address bits must be zero and the address no higher than the top
   assign addr_in_range = (addr_reg[12:10] == 3'h0) && (addr_reg <= ADDR_TOP);
   assign in_mem = addr_in_range && (addr_reg != ADDR_PORT_CONFIG) && (addr_reg != ADDR_READBACK_SEL)
                   && (addr_reg != ADDR_UPDATE);

   // A stall keeps every counter, so a resumed transfer carries on at the very next bit
   // Transfer sequencer: instruction, data bytes, then idle until chip select rises
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_INSTR;
         bit_cnt_reg <= 4'h0;
         instr_sr_reg <= 16'h0000;
         data_sr_reg <= 8'h00;
         instr_reg <= '0;
         addr_reg <= 13'h0000;
         bytes_left_reg <= 2'h0;
      end else if (cs_rise) begin
         // Byte boundary in the instruction or in a short transfer stalls; anything else starts over
         if (bit_cnt_reg[2:0] != 3'h0 || state_reg == ST_DONE
             || (state_reg == ST_DATA && instr_reg.transfer_length_field == LEN_STREAM)) begin
            state_reg <= ST_INSTR;
            bit_cnt_reg <= 4'h0;
         end
      end else if (sclk_rise) begin
         case (state_reg)
            ST_INSTR: begin
               instr_sr_reg <= instr_word;
               bit_cnt_reg <= bit_cnt_reg + 4'h1;
               if (bit_cnt_reg == INSTR_LAST_BIT) begin
                  instr_reg <= instr_t'(instr_word);
                  addr_reg <= instr_word[12:0];
                  bytes_left_reg <= instr_word[14:13];
                  state_reg <= ST_DATA;
               end
            end
            ST_DATA: begin
               data_sr_reg <= data_byte;
               bit_cnt_reg <= {1'b0, bit_cnt_reg[2:0] + 3'h1};
               if (bit_cnt_reg[2:0] == BYTE_LAST_BIT) begin
                  addr_reg <= next_addr(addr_reg, lsb_first);
                  bytes_left_reg <= bytes_left_reg - 2'h1;
                  if (last_fixed_byte) begin
                     state_reg <= ST_DONE;
                  end else if (instr_reg.transfer_length_field == LEN_STREAM && addr_reg == ADDR_TOP) begin
                     state_reg <= ST_DONE;
                  end
               end
            end
            default: begin
               state_reg <= ST_DONE;
            end
         endcase
      end
   end

   // Limitation: soft reset bits are stored but do nothing, so only the host can undo a bad setting
   // Serial byte writes: config and readback select act at once, update pulses, the rest go to the shadow bank
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         port_config_reg <= PORT_CONFIG_RESET;
         readback_sel_reg <= READBACK_SEL_RESET;
         update_reg <= 1'b0;
      end else begin
         update_reg <= 1'b0; // Update bit clears itself
         if (byte_done && !instr_reg.read && addr_in_range) begin
            if (addr_reg == ADDR_PORT_CONFIG) begin
               port_config_reg <= data_byte;
            end else if (addr_reg == ADDR_READBACK_SEL) begin
               readback_sel_reg <= data_byte;
            end else if (addr_reg == ADDR_UPDATE) begin
               update_reg <= data_byte[UPDATE_BIT];
            end
         end
      end
   end

   assign update_pulse_out = update_reg;

   // Reserved and unused locations are written like any other, so a stream never skips them
   // Shadow write request built from the byte just completed
   always_comb begin
      mem_wr.en = byte_done && !instr_reg.read && in_mem;
      mem_wr.addr = addr_reg[MEM_AW-1:0];
      mem_wr.data = data_byte;
   end

   shadow_active_store u_store (
      .clk_in(clk_in),
      .rst_n_in(rst_n),
      .wr_in(mem_wr),
      .update_in(update_reg),
      .rd_addr_in(addr_reg[MEM_AW-1:0]),
      .rd_active_in(readback_sel_reg[RBSEL_ACTIVE_BIT]),
      .rd_data_out(mem_rd_data)
   );

   // The bank read is registered, so its data lag the address by one cycle, well inside half a bit
   // Readback byte; out-of-range addresses and the update register read as zero
   always_comb begin
      if (!addr_in_range || addr_reg == ADDR_UPDATE) begin
         rd_byte = 8'h00;
      end else if (addr_reg == ADDR_PORT_CONFIG) begin
         rd_byte = port_config_reg;
      end else if (addr_reg == ADDR_READBACK_SEL) begin
         rd_byte = readback_sel_reg;
      end else begin
         rd_byte = mem_rd_data;
      end
   end

   assign rd_ordered = lsb_first ? reverse8(rd_byte) : rd_byte;
   assign reading = (state_reg == ST_DATA) && instr_reg.read;

   // Launch read bits on the falling edge; a fresh byte is loaded at each boundary.
   // The address moved half a clock earlier, which leaves ample cycles for the bank read.
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         out_sr_reg <= 8'h00;
         dout_reg <= 1'b0;
      end else if (sclk_fall && reading) begin
         if (bit_cnt_reg[2:0] == 3'h0) begin
            dout_reg <= rd_ordered[7];
            out_sr_reg <= {rd_ordered[6:0], 1'b0};
         end else begin
            dout_reg <= out_sr_reg[7];
            out_sr_reg <= {out_sr_reg[6:0], 1'b0};
         end
      end
   end

   // Both pins share one bit flop; only the enables differ, so switching pins never disturbs the data
   // Pin drivers: released whenever chip select is high or no read is running
   assign sdio_out = dout_reg;
   assign readback_output_line_out = dout_reg;
   assign sdio_oe_out = ~cs_n && reading && !sdo_active;
   assign readback_output_line_oe_out = ~cs_n && reading && sdo_active;

endmodule : serial_control_port

`default_nettype wire

// ### design/serial_port_pkg.sv
// Constants and types shared by the serial control port and its register store.
// Assumes a single 10 MHz system clock; the serial clock is sampled, not used as a clock.
`default_nettype none

package serial_port_pkg;

   // Register map
   localparam logic [12:0] ADDR_PORT_CONFIG = 13'h0000;
   localparam logic [12:0] ADDR_READBACK_SEL = 13'h0004;
   localparam logic [12:0] ADDR_UPDATE = 13'h0232;
   localparam logic [12:0] ADDR_TOP = 13'h0232;
   localparam int MEM_DEPTH = 563;
   localparam int MEM_AW = 10;

   // Field positions
   localparam int CFG_SDO_ACTIVE_BIT = 0;
   localparam int CFG_SDO_ACTIVE_MIRROR_BIT = 7;
   localparam int CFG_LSB_FIRST_BIT = 1;
   localparam int CFG_LSB_FIRST_MIRROR_BIT = 6;
   localparam int RBSEL_ACTIVE_BIT = 0;
   localparam int UPDATE_BIT = 0;

   // Reset values
   localparam logic [7:0] PORT_CONFIG_RESET = 8'h18;
   localparam logic [7:0] READBACK_SEL_RESET = 8'h00;

   // Length field codes
   localparam logic [1:0] LEN_ONE = 2'h0;
   localparam logic [1:0] LEN_TWO = 2'h1;
   localparam logic [1:0] LEN_THREE = 2'h2;
   localparam logic [1:0] LEN_STREAM = 2'h3;

   // Bit counts
   localparam logic [3:0] INSTR_LAST_BIT = 4'hf;
   localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

   // Timing: system clock and the bench serial clock period
   localparam int CLK_PERIOD_NS = 100;
   localparam int SCLK_PERIOD_NS = 800;
   localparam int SCLK_PERIOD_CYCLES = SCLK_PERIOD_NS / CLK_PERIOD_NS;

   // Instruction word: read/write, length, start address
   typedef struct packed {
      logic read;
      logic [1:0] transfer_length_field;
      logic [12:0] start_address_field;
   } instr_t;

   // Write request into the register store
   typedef struct packed {
      logic en;
      logic [MEM_AW-1:0] addr;
      logic [7:0] data;
   } mem_wr_t;

   typedef enum logic [1:0] {
      ST_INSTR = 2'h0,
      ST_DATA = 2'h1,
      ST_DONE = 2'h3
   } port_state_t;

endpackage : serial_port_pkg

`default_nettype wire

// ### design/shadow_active_store.sv
// Shadow buffer and active register banks for addresses 0x001..0x231 except 0x004, below register_update_trigger.
// Assumes the caller decodes addresses; read data is registered one cycle after the address.
`default_nettype none

module shadow_active_store
   import serial_port_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire mem_wr_t wr_in,
   input wire logic update_in,
   input wire logic [MEM_AW-1:0] rd_addr_in,
   input wire logic rd_active_in,
   output logic [7:0] rd_data_out
);

   logic [7:0] shadow_mem [0:MEM_DEPTH-1];
   logic [7:0] active_mem [0:MEM_DEPTH-1];

   // Shadow bank takes serial writes; update copies the whole bank at one edge
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < MEM_DEPTH; i++) begin
            shadow_mem[i] <= 8'h00;
            active_mem[i] <= 8'h00;
         end
      end else begin
         if (wr_in.en) begin
            shadow_mem[wr_in.addr] <= wr_in.data;
         end
         if (update_in) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
               active_mem[i] <= shadow_mem[i];
            end
         end
      end
   end

   // Registered read from the chosen bank
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_data_out <= 8'h00;
      end else if (rd_active_in) begin
         rd_data_out <= active_mem[rd_addr_in];
      end else begin
         rd_data_out <= shadow_mem[rd_addr_in];
      end
   end

endmodule : shadow_active_store

`default_nettype wire
